// ===== hw/ebs_error_break.sv
// Top: error, break-event and internal-error signalling with registers
//
// Contract
// - Normal mode: output shows unmasked FP error
// - Stop-clock: output shows only pending break
// - Break indication held until stop-clock released
// - Probe request during stop-clock is break
// - Internal error held until reset or init
// - Internal error issues shutdown bus request
// - Ignore input set: skip pending numeric errors
// - Ignore input clear: fault on pending error
// - Enable bit set: ignore input disregarded
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module ebs_error_break
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [ebs_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ebs_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [ebs_pkg::DATA_W-1:0] regRdata,
  // Pins from the chipset
  input wire logic stop_clock_in_n,
  input wire logic ignore_numeric_error_in_n,
  input wire logic probe_request_in_n,
  input wire logic softInitInN,
  // Pins to the chipset
  output logic error_or_break_out_n,
  output logic internal_error_out_n,
  // Core events
  input wire logic fpErrorDetect,
  input wire logic fpInstrValid,
  input wire logic fpInstrIsControl,
  input wire logic breakEventDetect,
  input wire logic internalErrorDetect,
  // Core requests
  output logic fpExceptionReq,
  output logic fpIgnoreAck,
  output logic shutdownReq,
  output logic irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_q;
  logic rstSyncN;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rstPipe_q <= 2'h0;
    else
      rstPipe_q <= {rstPipe_q[0], 1'b1};
  end

  assign rstSyncN = rstPipe_q[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  ebs_sync_if syncBus ();
  logic stopActive;
  logic ignoreActive;

  assign syncBus.rawN[ebs_pkg::SYNC_STOP] = stop_clock_in_n;
  assign syncBus.rawN[ebs_pkg::SYNC_IGNORE] = ignore_numeric_error_in_n;

  ebs_sync uSync
  (
    .clk_sys(clk_sys),
    .rstSyncN(rstSyncN),
    .pins(syncBus.sync)
  );

  assign stopActive = !syncBus.syncN[ebs_pkg::SYNC_STOP];
  assign ignoreActive = !syncBus.syncN[ebs_pkg::SYNC_IGNORE];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [ebs_pkg::CTRL_W-1:0] ctrl_q;
  logic [ebs_pkg::EV_W-1:0] intStatus_q;
  logic [ebs_pkg::EV_W-1:0] intEnable_q;
  logic wrCtrl;
  logic wrEnable;
  logic wrClear;
  logic fpSoftClear;
  logic neBit;
  logic shutdownEn;

  assign wrCtrl = regWrite && (regAddr == ebs_pkg::OFS_CTRL);
  assign wrEnable = regWrite && (regAddr == ebs_pkg::OFS_INT_ENABLE);
  assign wrClear = regWrite && (regAddr == ebs_pkg::OFS_INT_CLEAR);
  assign fpSoftClear = wrCtrl && regWdata[ebs_pkg::CTRL_FP_CLEAR_BIT];
  assign neBit = ctrl_q[ebs_pkg::CTRL_NE_BIT];
  assign shutdownEn = ctrl_q[ebs_pkg::CTRL_SHUTDOWN_EN_BIT];

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      ctrl_q <= ebs_pkg::CTRL_RESET;
      intEnable_q <= ebs_pkg::EV_RESET;
    end
    else
    begin
      if (wrCtrl)
        ctrl_q <= regWdata[ebs_pkg::CTRL_W-1:0];
      if (wrEnable)
        intEnable_q <= regWdata[ebs_pkg::EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode tracking
  // ----------------------------------------------------------------
  ebs_pkg::ebs_mode_e mode_q;
  ebs_pkg::ebs_mode_e mode_d;
  logic probeActive;
  logic breakSet;

  assign probeActive = !probe_request_in_n;
  assign breakSet = stopActive && (breakEventDetect || probeActive);

  // released by controller
  // Leaving stop-clock is the only way out of a break; the controller
  // is expected to answer the indication by releasing the pin.
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      ebs_pkg::ST_NORMAL:
        if (breakSet)
          mode_d = ebs_pkg::ST_BREAK;
        else if (stopActive)
          mode_d = ebs_pkg::ST_STOPPED;
      ebs_pkg::ST_STOPPED:
        if (!stopActive)
          mode_d = ebs_pkg::ST_NORMAL;
        else if (breakSet)
          mode_d = ebs_pkg::ST_BREAK;
      ebs_pkg::ST_BREAK:
        if (!stopActive)
          mode_d = ebs_pkg::ST_NORMAL;
      default:
        mode_d = ebs_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      mode_q <= ebs_pkg::ST_NORMAL;
    else
      mode_q <= mode_d;
  end

  // ----------------------------------------------------------------
  // Floating-point error state
  // ----------------------------------------------------------------
  logic fpPending_q;
  logic fpFault;
  logic fpSkip;
  logic fpIssue;
  logic softInit;

  assign softInit = !softInitInN;
  assign fpIssue = fpInstrValid && !fpInstrIsControl && fpPending_q;
  assign fpFault = fpIssue && (neBit || !ignoreActive);
  // pin sampled late
  // A pin changed by the I/O write settles two cycles later, so the
  // chipset must have it valid at target ready of that write.
  assign fpSkip = fpIssue && !neBit && ignoreActive;

  // New error wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      fpPending_q <= 1'b0;
    else if (fpErrorDetect)
      fpPending_q <= 1'b1;
    else if (fpSoftClear || softInit)
      fpPending_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      fpExceptionReq <= 1'b0;
      fpIgnoreAck <= 1'b0;
    end
    else
    begin
      fpExceptionReq <= fpFault;
      fpIgnoreAck <= fpSkip;
    end
  end

  // ----------------------------------------------------------------
  // Multiplexed error / break pin
  // ----------------------------------------------------------------
  logic showError;

  assign showError = (mode_d == ebs_pkg::ST_BREAK) ||
    (!stopActive && (fpPending_q || fpErrorDetect));

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      error_or_break_out_n <= 1'b1;
    else
      error_or_break_out_n <= !showError;
  end

  // ----------------------------------------------------------------
  // Internal error and shutdown
  // ----------------------------------------------------------------
  logic internal_error_out_n_q;
  logic ierrRise;

  assign ierrRise = internalErrorDetect && !internal_error_out_n_q;

  // held until init
  // A fresh internal error beats a simultaneous soft init
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      internal_error_out_n_q <= 1'b0;
    else if (internalErrorDetect)
      internal_error_out_n_q <= 1'b1;
    else if (softInit)
      internal_error_out_n_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      internal_error_out_n <= 1'b1;
      shutdownReq <= 1'b0;
    end
    else
    begin
      internal_error_out_n <= !(internalErrorDetect || (internal_error_out_n_q && !softInit));
      shutdownReq <= ierrRise && shutdownEn;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  logic [ebs_pkg::EV_W-1:0] events;
  logic [ebs_pkg::EV_W-1:0] clearMask;

  assign events[ebs_pkg::EV_FP_ERROR] = fpErrorDetect && !fpPending_q;
  assign events[ebs_pkg::EV_BREAK] = breakSet && (mode_q != ebs_pkg::ST_BREAK);
  assign events[ebs_pkg::EV_INTERNAL_ERROR_OUT_N] = ierrRise;
  assign events[ebs_pkg::EV_FP_EXCEPTION] = fpFault;
  assign clearMask = wrClear ? regWdata[ebs_pkg::EV_W-1:0] : ebs_pkg::EV_RESET;

  // Set wins over a clear written in the same cycle
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      intStatus_q <= ebs_pkg::EV_RESET;
      irq <= 1'b0;
    end
    else
    begin
      intStatus_q <= (intStatus_q & ~clearMask) | events;
      irq <= |(((intStatus_q & ~clearMask) | events) & intEnable_q);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [ebs_pkg::STAT_W-1:0] statusWord;
  logic [ebs_pkg::DATA_W-1:0] readMux;

  assign statusWord[ebs_pkg::STAT_FP_PENDING_BIT] = fpPending_q;
  assign statusWord[ebs_pkg::STAT_BREAK_BIT] = (mode_q == ebs_pkg::ST_BREAK);
  assign statusWord[ebs_pkg::STAT_INTERNAL_ERROR_OUT_N_BIT] = internal_error_out_n_q;
  assign statusWord[ebs_pkg::STAT_STOP_BIT] = stopActive;
  assign statusWord[ebs_pkg::STAT_IGNORE_BIT] = ignoreActive;

  // Write-only clear and unmapped offsets read as zero
  assign readMux =
    (regAddr == ebs_pkg::OFS_CTRL) ?
      {{(ebs_pkg::DATA_W-ebs_pkg::CTRL_W){1'b0}}, ctrl_q} :
    (regAddr == ebs_pkg::OFS_STATUS) ?
      {{(ebs_pkg::DATA_W-ebs_pkg::STAT_W){1'b0}}, statusWord} :
    (regAddr == ebs_pkg::OFS_INT_STATUS) ?
      {{(ebs_pkg::DATA_W-ebs_pkg::EV_W){1'b0}}, intStatus_q} :
    (regAddr == ebs_pkg::OFS_INT_ENABLE) ?
      {{(ebs_pkg::DATA_W-ebs_pkg::EV_W){1'b0}}, intEnable_q} :
      32'h0;

  // Data stand for exactly the cycle after the read strobe
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
      regRdata <= 32'h0;
    else if (regRead)
      regRdata <= readMux;
    else
      regRdata <= 32'h0;
  end

endmodule

// ===== hw/ebs_pkg.sv
// Package: constants for the error and break-event signalling block
package ebs_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h10;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_NE_BIT = 0;
  localparam int CTRL_SHUTDOWN_EN_BIT = 1;
  localparam int CTRL_FP_CLEAR_BIT = 2;
  localparam int CTRL_W = 2;
  localparam logic [1:0] CTRL_RESET = 2'h2;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int STAT_FP_PENDING_BIT = 0;
  localparam int STAT_BREAK_BIT = 1;
  localparam int STAT_INTERNAL_ERROR_OUT_N_BIT = 2;
  localparam int STAT_STOP_BIT = 3;
  localparam int STAT_IGNORE_BIT = 4;
  localparam int STAT_W = 5;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  localparam int EV_FP_ERROR = 0;
  localparam int EV_BREAK = 1;
  localparam int EV_INTERNAL_ERROR_OUT_N = 2;
  localparam int EV_FP_EXCEPTION = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] EV_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  localparam int SYNC_W = 2;
  localparam int SYNC_STOP = 0;
  localparam int SYNC_IGNORE = 1;
  localparam logic [1:0] SYNC_IDLE = 2'h3;

  typedef enum {
    ST_NORMAL,
    ST_STOPPED,
    ST_BREAK
  } ebs_mode_e;

endpackage

// ===== hw/ebs_sync.sv
// Two-stage synchroniser for the asynchronous control pins
`timescale 1ns/1ps
module ebs_sync
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstSyncN,
  // Pins
  ebs_sync_if.sync pins
);

  logic [ebs_pkg::SYNC_W-1:0] meta_q;
  logic [ebs_pkg::SYNC_W-1:0] stable_q;

  // ----------------------------------------------------------------
  // Two flops
  // ----------------------------------------------------------------
  // two-stage sync
  // The first stage feeds only the second; pins idle high in reset
  always_ff @(posedge clk_sys or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      meta_q <= ebs_pkg::SYNC_IDLE;
      stable_q <= ebs_pkg::SYNC_IDLE;
    end
    else
    begin
      meta_q <= pins.rawN;
      stable_q <= meta_q;
    end
  end

  assign pins.syncN = stable_q;

endmodule

// ===== hw/ebs_sync_if.sv
// Interface: raw asynchronous pins and their synchronised copies
`timescale 1ns/1ps
interface ebs_sync_if;
  logic [ebs_pkg::SYNC_W-1:0] rawN;
  logic [ebs_pkg::SYNC_W-1:0] syncN;

  modport owner
  (
    output rawN,
    input syncN
  );

  modport sync
  (
    input rawN,
    output syncN
  );
endinterface

// ===== sim/ebs_chipset_model.sv
// Model: chipset logic driving the stop-clock and ignore pins
`timescale 1ns/1ps
module ebs_chipset_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Bench controls
  input wire logic stopReq,
  input wire logic ignoreReq,
  input wire logic [3:0] releaseDelay,
  // Pins
  input wire logic error_or_break_out_n,
  output logic stop_clock_in_n,
  output logic ignore_numeric_error_in_n
);
  // ----
  // Stop-clock control
  // ----
  logic stopN_q;
  logic seen_q;
  logic [3:0] age_q;
  logic [3:0] dly_q;
  // driven long before any target ready
  assign ignore_numeric_error_in_n = ~ignoreReq;
  assign stop_clock_in_n = stopN_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stopN_q <= 1'b1;
      seen_q <= 1'b0;
      age_q <= 4'h0;
      dly_q <= 4'h0;
    end
    else if (stopN_q)
    begin
      stopN_q <= ~stopReq;
      seen_q <= 1'b0;
      age_q <= 4'h0;
      dly_q <= 4'h0;
    end
    else
    begin
      // Early lows may still be the fp error, so wait before trusting it
      age_q <= age_q + {3'h0, ~&age_q};
      if (age_q > 4'h3 && !error_or_break_out_n)
        seen_q <= 1'b1;
      if (seen_q)
        dly_q <= dly_q + 4'h1;
      if (seen_q && dly_q == releaseDelay)
        stopN_q <= 1'b1;
    end
  end
endmodule

// ===== sim/ebs_error_break_props.sv
// Checker: port-level properties of the error and break block
`timescale 1ns/1ps
module ebs_error_break_props
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pins
  input wire logic stop_clock_in_n,
  input wire logic ignore_numeric_error_in_n,
  input wire logic probe_request_in_n,
  input wire logic softInitInN,
  input wire logic error_or_break_out_n,
  input wire logic internal_error_out_n,
  // Core side
  input wire logic fpErrorDetect,
  input wire logic fpInstrValid,
  input wire logic fpInstrIsControl,
  input wire logic breakEventDetect,
  input wire logic internalErrorDetect,
  input wire logic fpExceptionReq,
  input wire logic fpIgnoreAck,
  input wire logic shutdownReq
);
  // ----
  // Shadow synchroniser
  // ----
  logic [1:0] stopSh_q;
  logic [1:0] ignSh_q;
  logic [2:0] age_q;
  logic ready;
  logic stopAct;
  logic ignAct;
  // Idle until the design's own sync has refilled after reset
  assign ready = &age_q;
  assign stopAct = stopSh_q[1];
  assign ignAct = ignSh_q[1];
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stopSh_q <= 2'h0;
      ignSh_q <= 2'h0;
      age_q <= 3'h0;
    end
    else
    begin
      stopSh_q <= {stopSh_q[0], ~stop_clock_in_n};
      ignSh_q <= {ignSh_q[0], ~ignore_numeric_error_in_n};
      age_q <= age_q + {2'h0, ~ready};
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rstn || !ready);
  fp_show_a: assert property (
    !stopAct && fpErrorDetect |=> !error_or_break_out_n) else $error("fp error not shown");
  stop_mask_a: assert property (
    stopAct && $past(stopAct) && error_or_break_out_n && probe_request_in_n
    && !breakEventDetect |=> error_or_break_out_n) else $error("output low with no break");
  brk_hold_a: assert property (
    $past(stopAct, 2) && $past(stopAct) && !$past(error_or_break_out_n)
    |-> !error_or_break_out_n) else $error("break indication dropped");
  probe_brk_a: assert property (
    stopAct && !probe_request_in_n |=> !error_or_break_out_n) else $error("probe not shown");
  event_brk_a: assert property (
    stopAct && breakEventDetect |=> !error_or_break_out_n) else $error("break not shown");
  internal_error_out_n_set_a: assert property (
    internalErrorDetect && softInitInN |=> !internal_error_out_n) else $error("internal_error_out_n not set");
  internal_error_out_n_hold_a: assert property (
    !internal_error_out_n && softInitInN |=> !internal_error_out_n) else $error("internal_error_out_n dropped");
  internal_error_out_n_init_a: assert property (
    !softInitInN && !internalErrorDetect |=> internal_error_out_n) else $error("init missed");
  shut_rise_a: assert property (
    shutdownReq |-> $fell(internal_error_out_n)) else $error("stray shutdown");
  fp_cause_a: assert property (
    fpExceptionReq || fpIgnoreAck |-> $past(fpInstrValid) && !$past(fpInstrIsControl))
    else $error("fp answer without instruction");
  fp_ack_a: assert property (
    fpIgnoreAck |-> $past(ignAct) && !fpExceptionReq) else $error("bad ignore ack");
endmodule
bind ebs_error_break ebs_error_break_props props (.clk_sys, .rstn, .stop_clock_in_n,
  .ignore_numeric_error_in_n, .probe_request_in_n, .softInitInN, .error_or_break_out_n,
  .internal_error_out_n, .fpErrorDetect, .fpInstrValid, .fpInstrIsControl,
  .breakEventDetect, .internalErrorDetect, .fpExceptionReq, .fpIgnoreAck, .shutdownReq);

// ===== sim/ebs_error_break_tb.sv
// Testbench: error, break-event and internal-error signalling
`timescale 1ns/1ps
module ebs_error_break_tb;
  // ----
  // Signals and tasks
  // ----
  typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} ebs_row_s;
  logic clk_sys, rstn, regWrite, regRead, softInitInN, probe_request_in_n;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic stop_clock_in_n, ignore_numeric_error_in_n, error_or_break_out_n;
  logic internal_error_out_n, fpErrorDetect, fpInstrValid, fpInstrIsControl;
  logic breakEventDetect, internalErrorDetect, fpExceptionReq, fpIgnoreAck;
  logic shutdownReq, irq, stopReq, ignoreReq;
  logic [3:0] releaseDelay;
  int n_errors = 0;
  int checks = 0;
  int n;
  ebs_row_s rows [7] = '{'{8'h00, 0, 0, 32'(ebs_pkg::CTRL_RESET)}, '{8'h04, 0, 0, 0},
    '{8'h08, 1, 32'hf, 0}, '{8'h0c, 1, 32'hf, 32'hf}, '{8'h10, 1, 32'hf, 0},
    '{8'h14, 1, 32'hffffffff, 0}, '{8'h00, 1, 32'h7, 32'h3}};
  ebs_error_break dut (.clk_sys, .rstn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .stop_clock_in_n, .ignore_numeric_error_in_n, .probe_request_in_n,
    .softInitInN, .error_or_break_out_n, .internal_error_out_n, .fpErrorDetect,
    .fpInstrValid, .fpInstrIsControl, .breakEventDetect, .internalErrorDetect,
    .fpExceptionReq, .fpIgnoreAck, .shutdownReq, .irq);
  ebs_chipset_model chipset (.clk_sys, .rstn, .stopReq, .ignoreReq, .releaseDelay,
    .error_or_break_out_n, .stop_clock_in_n, .ignore_numeric_error_in_n);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk("read data", regRdata, e);
  endtask
  // Bits: control, fp error, break, internal error, fp instruction, probe
  task automatic ev(input logic [5:0] m);
    @(posedge clk_sys);
    {fpInstrIsControl, fpErrorDetect, breakEventDetect, internalErrorDetect} <= m[5:2];
    fpInstrValid <= m[1];
    probe_request_in_n <= ~m[0];
    @(posedge clk_sys);
    {fpInstrIsControl, fpErrorDetect, breakEventDetect, internalErrorDetect} <= 4'h0;
    fpInstrValid <= 1'b0;
    probe_request_in_n <= 1'b1;
    #1;
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100us;
    n_errors++;
    end_sim();
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    {rstn, regWrite, regRead, fpErrorDetect, fpInstrValid, fpInstrIsControl} = 6'h0;
    {breakEventDetect, internalErrorDetect, stopReq, ignoreReq} = 4'h0;
    {softInitInN, probe_request_in_n, regAddr, regWdata, releaseDelay} = '1;
    tick(6);
    rstn <= 1'b1;
    tick(3);
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rc(rows[i].a, rows[i].e);
    end
    $display("register table done");
    wr(8'h00, 32'h2);
    ev(6'h10);
    chk("fp out", error_or_break_out_n, 0);
    tick(1);
    chk("irq", irq, 1);
    rc(8'h04, 32'h1);
    ev(6'h22);
    chk("control instr", {fpExceptionReq, fpIgnoreAck}, 0);
    ev(6'h02);
    chk("exception", {fpExceptionReq, fpIgnoreAck}, 2);
    ignoreReq <= 1'b1;
    tick(3);
    ev(6'h02);
    chk("ignored", {fpExceptionReq, fpIgnoreAck}, 1);
    wr(8'h00, 32'h3);
    ev(6'h02);
    chk("enable bit", {fpExceptionReq, fpIgnoreAck}, 2);
    ignoreReq <= 1'b0;
    wr(8'h00, 32'h6);
    wr(8'h10, 32'hf);
    wr(8'h0c, 32'h0);
    ev(6'h10);
    tick(1);
    chk("masked irq", irq, 0);
    rc(8'h08, 32'h1);
    wr(8'h10, 32'hf);
    wr(8'h0c, 32'hf);
    wr(8'h00, 32'h6);
    tick(1);
    chk("fp cleared", error_or_break_out_n, 1);
    $display("fp error test done");
    for (int k = 0; k < 2; k++)
    begin
      releaseDelay <= k ? 4'h1 : 4'h8;
      stopReq <= 1'b1;
      @(posedge clk_sys);
      stopReq <= 1'b0;
      tick(5);
      ev(6'h10);
      chk("fp hidden", error_or_break_out_n, 1);
      ev(k ? 6'h08 : 6'h01);
      chk("break shown", error_or_break_out_n, 0);
      rc(8'h04, 32'hb);
      n = 0;
      while (stop_clock_in_n === 1'b0 && n < 40)
      begin
        chk("break held", error_or_break_out_n, 0);
        tick(1);
        n++;
      end
      tick(3);
      chk("fp after stop", error_or_break_out_n, 0);
      wr(8'h00, 32'h6);
      tick(1);
      chk("fp cleared", error_or_break_out_n, 1);
    end
    $display("break test done");
    ev(6'h04);
    chk("internal_error_out_n", {internal_error_out_n, shutdownReq}, 1);
    tick(1);
    chk("internal_error_out_n held", {internal_error_out_n, shutdownReq}, 0);
    ev(6'h04);
    chk("no second shutdown", shutdownReq, 0);
    @(posedge clk_sys);
    softInitInN <= 1'b0;
    @(posedge clk_sys);
    softInitInN <= 1'b1;
    #1 chk("init clears", internal_error_out_n, 1);
    wr(8'h00, 32'h0);
    ev(6'h04);
    chk("shutdown off", {internal_error_out_n, shutdownReq}, 0);
    $display("internal error test done");
    @(posedge clk_sys);
    rstn <= 1'b0;
    #1 chk("reset clears", internal_error_out_n, 1);
    tick(3);
    rstn <= 1'b1;
    tick(3);
    rc(8'h00, 32'(ebs_pkg::CTRL_RESET));
    $display("reset test done");
    end_sim();
  end
endmodule
